// ==== fault_supervisor_menu.sv ====
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module fault_supervisor_menu
  import fault_supervisor_pkg::*;
#(
  parameter int unsigned         N_IN       = fault_supervisor_pkg::NUM_INPUTS,
  parameter int unsigned         GAP_CYCLES = fault_supervisor_pkg::SUPPLY_GAP_CYCLES,
  parameter logic [7:0]          HW_VERSION = 8'h01,  // arbitrary value
  parameter logic [15:0]         FW_VERSION = 16'h0100 // arbitrary value
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire fault_supervisor_pkg::wb_req_t wb_req_i,
  output fault_supervisor_pkg::wb_rsp_t      wb_rsp_o,
  // supervision inputs
  input  wire logic                    supply_low_i,
  input  wire logic                    supply_absent_i,
  input  wire logic                    gen_wire_loss_i,
  input  wire logic [N_IN-1:0]         input_wire_loss_i,
  input  wire logic [N_IN-1:0]         input_wire_kind_i,
  input  wire logic                    mem_verify_fail_i,
  input  wire logic [7:0]              mem_verify_code_i,
  input  wire logic                    controller_enable_input_i,
  // operator keys, one-cycle pulses
  input  wire fault_supervisor_pkg::keys_t   keys_i,
  // solenoid, lamps and menu state
  output logic [N_IN-1:0]              solenoid_enable_o,
  output logic                         led_red_o,
  output logic                         led_green_o,
  output logic [1:0]                   menu_level_o,
  output logic [3:0]                   menu_item_o,
  output logic [7:0]                   menu_value_o
);
  import fault_supervisor_pkg::*;

  initial begin
    if (N_IN < 1 || N_IN > 8) $error("N_IN must be 1..8");
    if (GAP_CYCLES < 1) $error("GAP_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       snap;
    logic [31:0]       rdata;
    logic              ack;
    logic              supply_flt;
    logic              wsupply_flt;
    logic [7:0]        input_flt;
    logic              mem_flt;
    logic [7:0]        mem_code;
    logic              en_prev;
    logic              en_seen_low;
    logic [31:0]       gap_cnt;
    logic [1:0]        level;
    logic [3:0]        item;
    logic [3:0]        sub_item;
    logic [3:0]        par_idx;
    logic [PARAM_ITEMS-1:0][7:0] par_val;   // packed: a packed struct holds no unpacked array
    logic [N_IN-1:0]   sol;
    logic              red;
    logic              green;
  } state_t;

  state_t st;
  state_t next_st;
  logic [31:0] diag_word;
  logic        wb_hit;
  logic [7:0]  wb_adr;

  always_comb begin
    diag_word = 32'h0000_0000;
    diag_word[DIAG_SUPPLY_BIT]  = st.supply_flt;
    diag_word[DIAG_WSUPPLY_BIT] = st.wsupply_flt;
    diag_word[DIAG_MEM_BIT]     = st.mem_flt;
    diag_word[DIAG_INPUT_LSB +: 8]  = st.input_flt;
    diag_word[DIAG_CODE_LSB +: 8]   = st.mem_code;
  end

  assign wb_adr = wb_req_i.adr[7:0];
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !st.ack;

  always_comb begin
    logic        all_block;
    logic        supply_now;
    logic        rearm;
    logic        wchk;
    logic [7:0]  wloss;
    logic [7:0]  pv;
    next_st    = st;
    all_block  = 1'b0;
    supply_now = 1'b0;
    rearm      = 1'b0;
    wchk       = st.ctrl[CTRL_WIRECHK_BIT];
    wloss      = 8'h00;
    pv         = 8'h00;

    // supply gap timer; saturates at GAP_CYCLES
    if (supply_absent_i) begin
      if (st.gap_cnt < GAP_CYCLES) next_st.gap_cnt = st.gap_cnt + 32'h0000_0001;
    end else begin
      next_st.gap_cnt = 32'h0000_0000;
    end

    // enable toggle: low seen, then rising edge rearms
    if (!controller_enable_input_i) next_st.en_seen_low = 1'b1;
    rearm = controller_enable_input_i && !st.en_prev && st.en_seen_low;
    next_st.en_prev = controller_enable_input_i;
    if (rearm) begin
      next_st.en_seen_low = 1'b0;
      next_st.supply_flt  = 1'b0;
      next_st.wsupply_flt = 1'b0;
      next_st.input_flt   = 8'h00;
    end

    // setting wins over the clear: cause still present keeps the fault
    supply_now = supply_low_i || (supply_absent_i && st.gap_cnt >= GAP_CYCLES);
    if (supply_now) next_st.supply_flt = 1'b1;
    if (wchk && gen_wire_loss_i) next_st.wsupply_flt = 1'b1;
    for (int i = 0; i < N_IN; i++) begin
      wloss[i] = wchk && input_wire_kind_i[i] && input_wire_loss_i[i];
    end
    next_st.input_flt = next_st.input_flt | wloss;

    if (mem_verify_fail_i) begin
      next_st.mem_flt  = 1'b1;
      next_st.mem_code = mem_verify_code_i;
    end

    // wishbone slave: one-cycle answer, ack dropped the next cycle
    next_st.ack = wb_hit;
    next_st.ctrl[CTRL_QUERY_BIT] = 1'b0;
    next_st.ctrl[CTRL_SAVED_BIT] = 1'b0;
    if (wb_hit) begin
      next_st.rdata = 32'h0000_0000;
      if (wb_req_i.we) begin
        if (wb_adr == CTRL_OFS && wb_req_i.sel[0]) begin
          next_st.ctrl[3:0] = wb_req_i.dat[3:0];
          if (wb_req_i.dat[CTRL_QUERY_BIT]) next_st.snap = diag_word;
          if (wb_req_i.dat[CTRL_SAVED_BIT] && !mem_verify_fail_i) begin
            next_st.mem_flt  = 1'b0;
            next_st.mem_code = 8'h00;
          end
        end
      end else begin
        case (wb_adr)
          CTRL_OFS:    next_st.rdata = {28'h0000000, st.ctrl[3:0]};
          DIAG_OFS:    next_st.rdata = diag_word;
          SNAP_OFS:    next_st.rdata = st.snap;
          VERSION_OFS: next_st.rdata = st.ctrl[CTRL_LINK_BIT] ?
                                       {8'h00, HW_VERSION, FW_VERSION} : 32'h0000_0000;
          MENU_OFS:    next_st.rdata = {20'h00000, st.par_idx, st.item, 2'b00, st.level};
          PARAM_OFS:   next_st.rdata = {24'h000000, st.par_val[st.par_idx[1:0]]};
          default:     next_st.rdata = 32'h0000_0000;
        endcase
      end
    end

    // cyclic operator menu
    case (st.level)
      2'd0: begin
        if (keys_i.mode) next_st.item = (st.item == TOP_ITEMS - 4'h1) ? 4'h0 : st.item + 4'h1;
        else if (keys_i.enter) begin
          next_st.level    = 2'd1;
          next_st.sub_item = 4'h0;
        end
      end
      2'd1: begin
        if (keys_i.mode) next_st.sub_item = (st.sub_item == SUB_ITEMS - 4'h1) ? 4'h0 : st.sub_item + 4'h1;
        else if (keys_i.enter) begin
          next_st.level   = 2'd2;
          next_st.par_idx = 4'h0;
          if (st.item == 4'h0) next_st.snap = diag_word;
        end
      end
      2'd2: begin
        pv = st.par_val[st.par_idx[1:0]];
        if (keys_i.plus) next_st.par_val[st.par_idx[1:0]] = pv + 8'h01;
        else if (keys_i.minus) next_st.par_val[st.par_idx[1:0]] = pv - 8'h01;
        else if (keys_i.enter) begin
          if (st.par_idx == PARAM_ITEMS - 4'h1) begin
            next_st.par_idx = 4'h0;
            next_st.level   = 2'd0;
          end else begin
            next_st.par_idx = st.par_idx + 4'h1;
          end
        end else if (keys_i.mode) begin
          next_st.level = 2'd1;
        end
      end
      default: next_st.level = 2'd0;
    endcase

    all_block = next_st.supply_flt || next_st.wsupply_flt || next_st.mem_flt;
    for (int i = 0; i < N_IN; i++) begin
      next_st.sol[i] = controller_enable_input_i && !all_block && !next_st.input_flt[i];
    end
    next_st.red   = all_block || (next_st.input_flt != 8'h00);
    next_st.green = !supply_low_i && !supply_absent_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.ctrl        <= CTRL_RESET;
      st.snap        <= 32'h0000_0000;
      st.rdata       <= 32'h0000_0000;
      st.ack         <= 1'b0;
      st.supply_flt  <= 1'b0;
      st.wsupply_flt <= 1'b0;
      st.input_flt   <= 8'h00;
      st.mem_flt     <= 1'b0;
      st.mem_code    <= 8'h00;
      st.en_prev     <= 1'b0;
      st.en_seen_low <= 1'b0;
      st.gap_cnt     <= 32'h0000_0000;
      st.level       <= 2'd0;
      st.item        <= 4'h0;
      st.sub_item    <= 4'h0;
      st.par_idx     <= 4'h0;
      for (int k = 0; k < PARAM_ITEMS; k++) st.par_val[k] <= PARAM_RESET;
      st.sol         <= '0;
      st.red         <= 1'b0;
      st.green       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_rsp_o.ack    = st.ack;
  assign wb_rsp_o.dat    = st.rdata;
  assign solenoid_enable_o = st.sol;
  assign led_red_o       = st.red;
  assign led_green_o     = st.green;
  assign menu_level_o    = st.level;
  assign menu_item_o     = (st.level == 2'd0) ? st.item : st.sub_item;
  assign menu_value_o    = st.par_val[st.par_idx[1:0]];

endmodule

// ==== fault_supervisor_pkg.sv ====
package fault_supervisor_pkg;

  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned SUPPLY_GAP_MS     = 250;
  localparam int unsigned SUPPLY_GAP_CYCLES = (CLK_HZ / 1000) * SUPPLY_GAP_MS;
  localparam int unsigned NUM_INPUTS        = 4;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] DIAG_OFS    = 8'h04;
  localparam logic [7:0] SNAP_OFS    = 8'h08;
  localparam logic [7:0] VERSION_OFS = 8'h0C;
  localparam logic [7:0] MENU_OFS    = 8'h10;
  localparam logic [7:0] PARAM_OFS   = 8'h14;

  // control register fields
  localparam int unsigned CTRL_WIRECHK_BIT = 0;
  localparam int unsigned CTRL_QUERY_BIT   = 1;
  localparam int unsigned CTRL_SAVED_BIT   = 2;
  localparam int unsigned CTRL_LINK_BIT    = 3;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;

  // diagnostic word fields
  localparam int unsigned DIAG_SUPPLY_BIT  = 0;
  localparam int unsigned DIAG_WSUPPLY_BIT = 1;
  localparam int unsigned DIAG_MEM_BIT     = 2;
  localparam int unsigned DIAG_INPUT_LSB   = 8;
  localparam int unsigned DIAG_CODE_LSB    = 16;

  // menu geometry
  localparam logic [3:0] TOP_ITEMS   = 4'hC;
  localparam logic [3:0] SUB_ITEMS   = 4'h4;
  localparam logic [3:0] PARAM_ITEMS = 4'h4;
  localparam logic [7:0] PARAM_RESET = 8'h00;

  typedef enum {
    MENU_TOP,
    MENU_SUB,
    MENU_PARAM
  } menu_level_t;

  typedef struct packed {
    logic mode;
    logic enter;
    logic plus;
    logic minus;
  } keys_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } wb_rsp_t;

endpackage

// ==== fault_supervisor_asserts.sv ====
`timescale 1ns/1ns
module fault_supervisor_asserts
  import fault_supervisor_pkg::*;
#(
  parameter int unsigned N_IN       = 4,
  parameter int unsigned GAP_CYCLES = 20
) (
  // clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // bus and causes
  input wire fault_supervisor_pkg::wb_req_t wb_req_i,
  input wire fault_supervisor_pkg::wb_rsp_t wb_rsp_o,
  input wire logic                          supply_low_i,
  input wire logic                          supply_absent_i,
  input wire logic                          mem_verify_fail_i,
  input wire fault_supervisor_pkg::keys_t   keys_i,
  // results
  input wire logic [N_IN-1:0]               solenoid_enable_o,
  input wire logic                          led_red_o,
  input wire logic                          led_green_o,
  input wire logic [1:0]                    menu_level_o,
  input wire logic [3:0]                    menu_item_o,
  input wire logic [7:0]                    menu_value_o
);
  int unsigned gap_cnt;
  // length of the current supply gap
  always_ff @(posedge clk_i)
    if (rst_i || !supply_absent_i) gap_cnt <= 0;
    else gap_cnt <= gap_cnt + 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_low; supply_low_i |=> led_red_o && solenoid_enable_o == '0; endproperty
  a_low: assert property (p_low) else $error("low supply not blocking");
  property p_gap; gap_cnt == GAP_CYCLES + 1 |-> ##[0:2] led_red_o; endproperty
  a_gap: assert property (p_gap) else $error("supply gap not flagged");
  property p_mem; mem_verify_fail_i |=> led_red_o && solenoid_enable_o == '0; endproperty
  a_mem: assert property (p_mem) else $error("memory fault not blocking");
  property p_green; supply_absent_i |=> !led_green_o; endproperty
  a_green: assert property (p_green) else $error("green lamp without supply");
  property p_mode;
    keys_i.mode && menu_level_o == 2'h0 |=>
      menu_item_o == (($past(menu_item_o) == TOP_ITEMS - 4'h1) ? 4'h0 : $past(menu_item_o) + 4'h1);
  endproperty
  a_mode: assert property (p_mode) else $error("menu item step wrong");
  property p_enter; keys_i.enter && !keys_i.mode && menu_level_o == 2'h0 |=> menu_level_o == 2'h1; endproperty
  a_enter: assert property (p_enter) else $error("enter did not descend");
  property p_plus;
    menu_level_o == 2'h2 && keys_i.plus && menu_value_o != 8'hFF |=> menu_value_o == $past(menu_value_o) + 8'h1;
  endproperty
  a_plus: assert property (p_plus) else $error("plus did not step value");
  property p_ack; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  c_gap: cover property (gap_cnt == GAP_CYCLES + 1);
  c_wrap: cover property (keys_i.mode && menu_item_o == TOP_ITEMS - 4'h1);
  c_plus: cover property (menu_level_o == 2'h2 && keys_i.plus);
endmodule
bind fault_supervisor_menu fault_supervisor_asserts #(.N_IN(N_IN), .GAP_CYCLES(GAP_CYCLES)) chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .supply_low_i(supply_low_i),
  .supply_absent_i(supply_absent_i), .mem_verify_fail_i(mem_verify_fail_i), .keys_i(keys_i),
  .solenoid_enable_o(solenoid_enable_o), .led_red_o(led_red_o), .led_green_o(led_green_o),
  .menu_level_o(menu_level_o), .menu_item_o(menu_item_o), .menu_value_o(menu_value_o));

// ==== keypad_model.sv ====
`timescale 1ns/1ns
module keypad_model
  import fault_supervisor_pkg::*;
(
  // clock
  input  wire logic                    clk_i,
  // operator side
  output fault_supervisor_pkg::keys_t keys_o,
  output logic                        enable_o
);
  initial begin
    keys_o   = '0;
    enable_o = 1'b1;
  end
  // one key press is a single-cycle pulse
  task automatic press(input logic [3:0] k);
    @(posedge clk_i) keys_o <= k;
    @(posedge clk_i) keys_o <= '0;
  endtask
  // short disable, then enable again
  task automatic toggle();
    @(posedge clk_i) enable_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    enable_o <= 1'b1;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import fault_supervisor_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, low, absent, gen, mfail, en, red, green;
  logic [3:0]  loss, kind, sol, item;
  logic [7:0]  code, val;
  logic [1:0]  lvl;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  wb_req_t     req;
  wb_rsp_t     rsp;
  keys_t       keys;
  int          errors = 0, checked = 0, k, n;
  always #10 clk_i = ~clk_i;
  // version values are arbitrary
  fault_supervisor_menu #(.GAP_CYCLES(20), .HW_VERSION(8'h5A), .FW_VERSION(16'hC3C3)) fault_supervisor_menu_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .supply_low_i(low), .supply_absent_i(absent),
    .gen_wire_loss_i(gen), .input_wire_loss_i(loss), .input_wire_kind_i(kind), .mem_verify_fail_i(mfail),
    .mem_verify_code_i(code), .controller_enable_input_i(en), .keys_i(keys), .solenoid_enable_o(sol),
    .led_red_o(red), .led_green_o(green), .menu_level_o(lvl), .menu_item_o(item), .menu_value_o(val));
  keypad_model keypad_model_inst (.clk_i(clk_i), .keys_o(keys), .enable_o(en));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i) req <= '{adr: {24'h0, a}, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 40);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic chk_out(input logic [3:0] s, input logic r);
    settle();
    `CHK("solenoid", s, sol)
    `CHK("red", r, red)
  endtask
  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // read data is judged where the answer appears
  always @(posedge clk_i)
    if (rsp.ack === 1'b1 && req.cyc === 1'b1 && req.we === 1'b0) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rsp.dat)
    end
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  initial begin
    void'($urandom(8));
    low    <= 1'b0;
    absent <= 1'b0;
    gen    <= 1'b0;
    mfail  <= 1'b0;
    loss   <= 4'h0;
    kind   <= 4'hF;
    code   <= 8'h00;
    req    <= '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_OFS, CTRL_RESET);
    rd(8'h20, 32'h0);
    rd(VERSION_OFS, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h9);
    rd(VERSION_OFS, 32'h005AC3C3);
    chk_out(4'hF, 1'b0);
    `CHK("green", 1'b1, green)
    @(posedge clk_i) low <= 1'b1;
    @(posedge clk_i) low <= 1'b0;
    chk_out(4'h0, 1'b1);
    rd(DIAG_OFS, 32'h1);
    wb(1'b1, CTRL_OFS, 32'hB);
    keypad_model_inst.toggle();
    chk_out(4'hF, 1'b0);
    rd(SNAP_OFS, 32'h1);
    @(posedge clk_i) absent <= 1'b1;
    repeat (15) @(posedge clk_i);
    @(negedge clk_i) `CHK("green", 1'b0, green)
    `CHK("red", 1'b0, red)
    repeat (10) @(posedge clk_i);
    absent <= 1'b0;
    chk_out(4'h0, 1'b1);
    keypad_model_inst.toggle();
    for (k = 0; k < 2; k++) begin
      wb(1'b1, CTRL_OFS, k ? 32'h8 : 32'h9);
      @(posedge clk_i) gen <= 1'b1;
      @(posedge clk_i) gen <= 1'b0;
      chk_out(k ? 4'hF : 4'h0, k == 0);
      keypad_model_inst.toggle();
    end
    // random input, first checkable, then not
    k = $urandom_range(3, 0);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, CTRL_OFS, 32'h9);
      kind <= m ? ~(4'h1 << k) : 4'hF;
      @(posedge clk_i) loss <= 4'h1 << k;
      @(posedge clk_i) loss <= 4'h0;
      chk_out(m ? 4'hF : ~(4'h1 << k), m == 0);
      rd(DIAG_OFS, m ? 32'h0 : 32'h100 << k);
      keypad_model_inst.toggle();
    end
    @(posedge clk_i) mfail <= 1'b1;
    code <= 8'($urandom);
    @(posedge clk_i) mfail <= 1'b0;
    chk_out(4'h0, 1'b1);
    rd(DIAG_OFS, {8'h0, code, 16'h4});
    keypad_model_inst.toggle();
    chk_out(4'h0, 1'b1);
    wb(1'b1, CTRL_OFS, 32'hD);
    chk_out(4'hF, 1'b0);
    for (k = 0; k < 13; k++) keypad_model_inst.press(4'h8);
    settle();
    `CHK("item", 4'h1, item)
    keypad_model_inst.press(4'h4);
    settle();
    `CHK("level", 2'h1, lvl)
    keypad_model_inst.press(4'h4);
    n = $urandom_range(5, 1);
    repeat (n) keypad_model_inst.press(4'h2);
    keypad_model_inst.press(4'h1);
    settle();
    `CHK("value", PARAM_RESET + 8'(n - 1), val)
    repeat (4) keypad_model_inst.press(4'h4);
    settle();
    `CHK("level", 2'h0, lvl)
    end_sim();
  end
endmodule
